/* shared/mcss_regs.vh */
`ifndef MCSS_REGS_VH
`define MCSS_REGS_VH

// register indexes (register port addresses)
`define MCSS_ADDR_CTRL2        5'h01
`define MCSS_ADDR_MSYNC        5'h0a
`define MCSS_ADDR_STATUS       5'h16
`define MCSS_ADDR_MASK         5'h17
`define MCSS_ADDR_STATE        5'h18
`define MCSS_ADDR_ACTIVE_CTRL2 5'h19
`define MCSS_ADDR_ACTIVE_MSYNC 5'h1a

// control_function_reg_two fields
`define MCSS_CTRL2_GEN_EN      0
`define MCSS_CTRL2_GEN_POL     1
`define MCSS_CTRL2_VAL_DIS     5
`define MCSS_CTRL2_RESET       32'h0000_0000

// multichip sync register fields
`define MCSS_MS_VAL_DLY_HI     31
`define MCSS_MS_VAL_DLY_LO     28
`define MCSS_MS_RX_EN          27
`define MCSS_MS_OUT_DLY_HI     22
`define MCSS_MS_OUT_DLY_LO     18
`define MCSS_MS_IN_DLY_HI      17
`define MCSS_MS_IN_DLY_LO      13
`define MCSS_MS_PRESET_HI      7
`define MCSS_MS_PRESET_LO      2
`define MCSS_MSYNC_RESET       32'h0000_0000

// interrupt status / mask bits
`define MCSS_IRQ_SYNC          0
`define MCSS_IRQ_SMP_ERR       1
`define MCSS_IRQ_UPDATE        2
`define MCSS_IRQ_WIDTH         3
`define MCSS_IRQ_RESET         3'h0

// sync generator divide: one sixteenth of core rate, half high half low
`define MCSS_GEN_DIV           16
`define MCSS_GEN_HALF          4'h7
`define MCSS_GEN_CNT_RESET     4'h0

// delay taps: one tap per core clock cycle in this implementation
`define MCSS_DLY_STEP_PS       75
`define MCSS_CLK_PERIOD_PS     10000

`define MCSS_STATE_RESET       6'h00

`endif

/* rtl/mcss_delay_line.v */
`include "mcss_regs.vh"

module mcss_delay_line #(
    parameter SEL_W = 5
) (
    // clock and reset
    input  wire             clock_i,
    input  wire             rst_n_i,
    // data
    input  wire             din_i,
    input  wire [SEL_W-1:0] sel_i,
    output reg              dout_o
);

    localparam DEPTH = 1 << SEL_W;

    reg [DEPTH-1:0] taps;

    // tap 0 is the input itself, so a zero word adds only the output flop
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            taps   <= {DEPTH{1'b0}};
            dout_o <= 1'b0;
        end
        else
        begin
            taps   <= {taps[DEPTH-2:0], din_i};
            dout_o <= (sel_i == {SEL_W{1'b0}}) ? din_i : taps[sel_i - 1'b1];
        end
    end

endmodule // mcss_delay_line

/* rtl/mcss_validator.v */
`include "mcss_regs.vh"

module mcss_validator #(
    parameter WIN_W = 4
) (
    // clock and reset
    input  wire             clock_i,
    input  wire             rst_n_i,
    // control
    input  wire             disable_i,
    input  wire [WIN_W-1:0] window_i,
    // delayed sync sample
    input  wire             sync_i,
    // result
    output reg              fail_o,
    output reg              check_o
);

    reg             prev;
    reg [WIN_W-1:0] run;
    wire            rise;
    wire            fall;
    wire            short_run;

    assign rise      = sync_i & ~prev;
    assign fall      = ~sync_i & prev;
    assign short_run = (run < window_i);

    // run counts cycles since the last transition, saturating
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prev    <= 1'b0;
            run     <= {WIN_W{1'b0}};
            fail_o  <= 1'b0;
            check_o <= 1'b0;
        end
        else
        begin
            prev    <= sync_i;
            check_o <= 1'b0;
            fail_o  <= 1'b0;
            if (rise | fall)
                run <= {WIN_W{1'b0}};
            else if (run != {WIN_W{1'b1}})
                run <= run + 1'b1;
            // setup: low long enough before the edge; hold: high long enough after
            if (!disable_i && (rise | fall))
            begin
                check_o <= 1'b1;
                fail_o  <= short_run;
            end
        end
    end

endmodule // mcss_validator

/* rtl/mcss_top.v */
// The strobed register port and the register offsets are this design's own decisions.
`include "mcss_regs.vh"

module mcss_top #(
    parameter STATE_W = 6,
    parameter DLY_W   = 5,
    parameter WIN_W   = 4
) (
    // clock and reset
    input  wire               clock_i,
    input  wire               rst_n_i,
    // register port
    input  wire [4:0]         reg_addr_i,
    input  wire [31:0]        reg_wdata_i,
    input  wire               reg_wr_i,
    input  wire               reg_rd_i,
    output reg  [31:0]        reg_rdata_o,
    // register transfer strobe pin
    input  wire               io_update_i,
    // sync pins
    input  wire               sync_input_pair_p_i,
    input  wire               sync_input_pair_n_i,
    output reg                sync_output_pair_p_o,
    output reg                sync_output_pair_n_o,
    output reg                sync_sample_error_o,
    // core state and interrupt
    output reg  [STATE_W-1:0] clock_state_o,
    output reg                irq_o
);

    // buffered (written) and active copies
    reg  [31:0]               buf_ctrl2;
    reg  [31:0]               buf_msync;
    reg  [31:0]               act_ctrl2;
    reg  [31:0]               act_msync;

    // interrupt registers
    reg  [`MCSS_IRQ_WIDTH-1:0] irq_status;
    reg  [`MCSS_IRQ_WIDTH-1:0] irq_mask;
    reg  [`MCSS_IRQ_WIDTH-1:0] irq_event;

    // pin synchronisers
    reg                       upd_meta;
    reg                       upd_sync;
    reg                       upd_prev;
    reg                       sin_meta;
    reg                       sin_sync;

    // generator
    reg  [3:0]                gen_cnt;
    reg                       gen_clk;
    reg                       gen_late;
    reg                       gen_sel;
    wire                      gen_dly;

    // receiver
    wire                      sin_dly;
    reg                       sin_prev;
    reg                       sync_pulse;
    reg  [STATE_W-1:0]        next_state;
    wire                      val_fail;
    wire                      val_check;

    // decoded active fields, update strobe edge and register write strobes
    wire                      gen_en;
    wire                      gen_pol;
    wire                      val_dis;
    wire                      rx_en;
    wire [DLY_W-1:0]          out_dly;
    wire [DLY_W-1:0]          in_dly;
    wire [WIN_W-1:0]          val_win;
    wire [STATE_W-1:0]        preset;
    wire                      upd_rise;
    wire                      wr_ctrl2;
    wire                      wr_msync;
    wire                      wr_status;
    wire                      wr_mask;

    assign gen_en    = act_ctrl2[`MCSS_CTRL2_GEN_EN];
    assign gen_pol   = act_ctrl2[`MCSS_CTRL2_GEN_POL];
    assign val_dis   = act_ctrl2[`MCSS_CTRL2_VAL_DIS];
    assign rx_en     = act_msync[`MCSS_MS_RX_EN];
    assign out_dly   = act_msync[`MCSS_MS_OUT_DLY_HI:`MCSS_MS_OUT_DLY_LO];
    assign in_dly    = act_msync[`MCSS_MS_IN_DLY_HI:`MCSS_MS_IN_DLY_LO];
    assign val_win   = act_msync[`MCSS_MS_VAL_DLY_HI:`MCSS_MS_VAL_DLY_LO];
    assign preset    = act_msync[`MCSS_MS_PRESET_HI:`MCSS_MS_PRESET_LO];

    assign wr_ctrl2  = reg_wr_i & (reg_addr_i == `MCSS_ADDR_CTRL2);
    assign wr_msync  = reg_wr_i & (reg_addr_i == `MCSS_ADDR_MSYNC);
    assign wr_status = reg_wr_i & (reg_addr_i == `MCSS_ADDR_STATUS);
    assign wr_mask   = reg_wr_i & (reg_addr_i == `MCSS_ADDR_MASK);

    assign upd_rise  = upd_sync & ~upd_prev;

    // pins come from another domain: two flops before any logic, except the sync pair's AND, which feeds the first flop
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            upd_meta <= 1'b0;
            upd_sync <= 1'b0;
            upd_prev <= 1'b0;
            sin_meta <= 1'b0;
            sin_sync <= 1'b0;
        end
        else
        begin
            upd_meta <= io_update_i;
            upd_sync <= upd_meta;
            upd_prev <= upd_sync;
            // differential pair: high only when the pair says so
            sin_meta <= sync_input_pair_p_i & ~sync_input_pair_n_i;
            sin_sync <= sin_meta;
        end
    end

    // ctrl2 and msync writes land in the buffers; neither acts until the transfer strobe
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            buf_ctrl2 <= `MCSS_CTRL2_RESET;
            buf_msync <= `MCSS_MSYNC_RESET;
        end
        else
        begin
            if (wr_ctrl2)
                buf_ctrl2 <= reg_wdata_i;
            if (wr_msync)
                buf_msync <= reg_wdata_i;
        end
    end

    // one strobe shared by many devices makes their updates coincide
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            act_ctrl2 <= `MCSS_CTRL2_RESET;
            act_msync <= `MCSS_MSYNC_RESET;
        end
        else if (upd_rise)
        begin
            act_ctrl2 <= buf_ctrl2;
            act_msync <= buf_msync;
        end
    end

    // sync generator: divide by sixteen, high for eight, low for eight
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            gen_cnt <= `MCSS_GEN_CNT_RESET;
            gen_clk <= 1'b0;
        end
        else if (!gen_en)
        begin
            gen_cnt <= `MCSS_GEN_CNT_RESET;
            gen_clk <= 1'b0;
        end
        else
        begin
            gen_cnt <= gen_cnt + 1'b1;
            gen_clk <= (gen_cnt <= `MCSS_GEN_HALF);
        end
    end

    // single clock: the falling-edge choice becomes a half-period
    // later launch, approximated here as one extra core cycle
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            gen_late <= 1'b0;
            gen_sel  <= 1'b0;
        end
        else
        begin
            gen_late <= gen_clk;
            gen_sel  <= gen_pol ? gen_late : gen_clk;
        end
    end

    // output delay: one tap per word step
    mcss_delay_line #(
        .SEL_W (DLY_W)
    ) u_out_dly (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .din_i   (gen_sel),
        .sel_i   (out_dly),
        .dout_o  (gen_dly)
    );

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync_output_pair_p_o <= 1'b0;
            sync_output_pair_n_o <= 1'b1;
        end
        else
        begin
            sync_output_pair_p_o <= gen_dly;
            sync_output_pair_n_o <= ~gen_dly;
        end
    end

    // input delay ahead of edge detection
    mcss_delay_line #(
        .SEL_W (DLY_W)
    ) u_in_dly (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .din_i   (sin_sync),
        .sel_i   (in_dly),
        .dout_o  (sin_dly)
    );

    // edge detector: one pulse per rising edge, so pulses follow
    // the input frequency
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sin_prev   <= 1'b0;
            sync_pulse <= 1'b0;
        end
        else
        begin
            sin_prev   <= sin_dly;
            sync_pulse <= rx_en & sin_dly & ~sin_prev;
        end
    end

    // clock-state counter keeps running even with the receiver off
    always @*
    begin
        if (sync_pulse)
            next_state = preset;
        else
            next_state = clock_state_o + 1'b1;
    end

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            clock_state_o <= `MCSS_STATE_RESET;
        else
            clock_state_o <= next_state;
    end

    // setup/hold checking on the same delayed sample
    mcss_validator #(
        .WIN_W (WIN_W)
    ) u_val (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_i),
        .disable_i (val_dis | ~rx_en),
        .window_i  (val_win),
        .sync_i    (sin_dly),
        .fail_o    (val_fail),
        .check_o   (val_check)
    );

    // error level: set by a failed check, cleared by a clean one or
    // by disabling validation
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            sync_sample_error_o <= 1'b0;
        else if (val_dis)
            sync_sample_error_o <= 1'b0;
        else if (val_check)
            sync_sample_error_o <= val_fail;
    end

    // interrupt events
    always @*
    begin
        irq_event = `MCSS_IRQ_RESET;
        irq_event[`MCSS_IRQ_SYNC]    = sync_pulse;
        irq_event[`MCSS_IRQ_SMP_ERR] = val_check & val_fail;
        irq_event[`MCSS_IRQ_UPDATE]  = upd_rise;
    end

    // write-one-to-clear; a new event in the same cycle wins
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            irq_status <= `MCSS_IRQ_RESET;
            irq_mask   <= `MCSS_IRQ_RESET;
            irq_o      <= 1'b0;
        end
        else
        begin
            if (wr_status)
                irq_status <= (irq_status & ~reg_wdata_i[`MCSS_IRQ_WIDTH-1:0]) | irq_event;
            else
                irq_status <= irq_status | irq_event;
            if (wr_mask)
                irq_mask <= reg_wdata_i[`MCSS_IRQ_WIDTH-1:0];
            irq_o <= |(irq_status & irq_mask);
        end
    end

    // read data valid only in the cycle after the strobe
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            reg_rdata_o <= 32'h0000_0000;
        else if (!reg_rd_i)
            reg_rdata_o <= 32'h0000_0000;
        else
        begin
            case (reg_addr_i)
                `MCSS_ADDR_CTRL2:        reg_rdata_o <= buf_ctrl2;
                `MCSS_ADDR_MSYNC:        reg_rdata_o <= buf_msync;
                `MCSS_ADDR_ACTIVE_CTRL2: reg_rdata_o <= act_ctrl2;
                `MCSS_ADDR_ACTIVE_MSYNC: reg_rdata_o <= act_msync;
                `MCSS_ADDR_STATUS:
                    reg_rdata_o <= {{(32-`MCSS_IRQ_WIDTH){1'b0}}, irq_status};
                `MCSS_ADDR_MASK:
                    reg_rdata_o <= {{(32-`MCSS_IRQ_WIDTH){1'b0}}, irq_mask};
                `MCSS_ADDR_STATE:
                    reg_rdata_o <= {{(32-STATE_W){1'b0}}, clock_state_o};
                default:                 reg_rdata_o <= 32'h0000_0000;
            endcase
        end
    end

endmodule // mcss_top

/* bench/mcss_top_properties.sv */
`include "mcss_regs.vh"

module mcss_top_properties #(
    parameter STATE_W = 6
) (
    input wire logic               clock_i,
    input wire logic               rst_n_i,
    input wire logic [4:0]         reg_addr_i,
    input wire logic               reg_rd_i,
    input wire logic [31:0]        reg_rdata_o,
    input wire logic               sync_input_pair_p_i,
    input wire logic               sync_input_pair_n_i,
    input wire logic               sync_output_pair_p_o,
    input wire logic               sync_output_pair_n_o,
    input wire logic               sync_sample_error_o,
    input wire logic [STATE_W-1:0] clock_state_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // cycles since the sync input last toggled, saturating
    logic [5:0] since_tog;
    logic       lvl_d;
    wire        lvl = sync_input_pair_p_i & ~sync_input_pair_n_i;
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            since_tog <= 6'h00;
            lvl_d     <= 1'b0;
        end
        else
        begin
            lvl_d     <= lvl;
            since_tog <= (lvl != lvl_d) ? 6'h00 : since_tog + {5'h0, since_tog != 6'h3f};
        end
    end

    chk_out_pair: assert property (sync_output_pair_n_o == !sync_output_pair_p_o)
        else $error("sync output pair not complementary");
    chk_high_eight: assert property ($rose(sync_output_pair_p_o) |->
        sync_output_pair_p_o[*8] ##1 !sync_output_pair_p_o)
        else $error("sync output high phase not 8 cycles");
    chk_low_eight: assert property ($fell(sync_output_pair_p_o) |->
        !sync_output_pair_p_o[*8] ##1 sync_output_pair_p_o)
        else $error("sync output low phase not 8 cycles");
    chk_state_resume: assert property (clock_state_o != $past(clock_state_o) + 1'b1 |=>
        clock_state_o == $past(clock_state_o) + 1'b1)
        else $error("state counter did not resume after preset");
    chk_jump_cause: assert property (clock_state_o != $past(clock_state_o) + 1'b1 |->
        since_tog <= 6'd40)
        else $error("state counter jumped without a sync edge");
    chk_err_cause: assert property ($rose(sync_sample_error_o) |-> since_tog <= 6'd40)
        else $error("sample error rose without input activity");
    chk_rd_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data not zero outside read");
    chk_unmapped_rd: assert property (reg_rd_i && reg_addr_i == 5'h1f |=> reg_rdata_o == 32'h0)
        else $error("unmapped read not zero");
    chk_state_read: assert property (reg_rd_i && reg_addr_i == `MCSS_ADDR_STATE |=>
        reg_rdata_o[5:0] == $past(clock_state_o))
        else $error("state read mismatch");

    cover property ($rose(sync_output_pair_p_o));
    cover property ($rose(sync_sample_error_o));
    cover property (clock_state_o != $past(clock_state_o) + 1'b1);
endmodule // mcss_top_properties

/* bench/mcss_sync_source.sv */
module mcss_sync_source (
    // clock
    input  wire logic       clock_i,
    // control
    input  wire logic       run_i,
    input  wire logic [5:0] half_i,
    // sync pair
    output logic            p_o,
    output logic            n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] cnt = 6'h00;
    initial p_o = 1'b0;
    assign n_o = ~p_o;
    // parked low between bursts so the receiver sees no stray edge
    always @(posedge clock_i)
    begin
        if (!run_i)
        begin
            p_o <= 1'b0;
            cnt <= 6'h00;
        end
        else if (cnt + 6'h01 >= half_i)
        begin
            p_o <= ~p_o;
            cnt <= 6'h00;
        end
        else
            cnt <= cnt + 6'h01;
    end
endmodule // mcss_sync_source

/* bench/tb_mcss_top.sv */
`include "mcss_regs.vh"

module tb_mcss_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i     = 1'b0;
    logic        rst_n_i     = 1'b0;
    logic [4:0]  reg_addr_i  = 5'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic        reg_wr_i    = 1'b0;
    logic        reg_rd_i    = 1'b0;
    logic        io_update_i = 1'b0;
    logic        run         = 1'b0;
    logic [5:0]  half        = 6'd40;
    logic [5:0]  pre, s0;
    wire  [31:0] rdata;
    wire  [5:0]  state;
    wire         sin_p, sin_n, sout_p, sout_n, err, irq;
    int          errors = 0;
    int          cmp_count = 0;
    int          l1, l2, hi, lo;
    logic [4:0]  n2;
    logic [31:0] exp_q[$], msk_q[$];
    logic        rd_q = 1'b0;
    localparam logic [31:0] FMSK = 32'hf87f_e0fc;

    always #5 clock_i = ~clock_i;

    mcss_top i_mcss_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(rdata), .io_update_i(io_update_i), .sync_input_pair_p_i(sin_p),
        .sync_input_pair_n_i(sin_n), .sync_output_pair_p_o(sout_p),
        .sync_output_pair_n_o(sout_n), .sync_sample_error_o(err),
        .clock_state_o(state), .irq_o(irq));
    mcss_sync_source i_mcss_sync_source (.clock_i(clock_i), .run_i(run), .half_i(half),
        .p_o(sin_p), .n_o(sin_n));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge clock_i)
    begin
        if (rd_q)
            check("rdata", rdata & msk_q.pop_front(), exp_q.pop_front());
        rd_q <= reg_rd_i;
    end

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clock_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge clock_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
    endtask

    task automatic upd();
        @(posedge clock_i);
        io_update_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        io_update_i <= 1'b0;
        repeat (2) @(posedge clock_i);
    endtask

    function automatic logic [31:0] mk(input logic [3:0] w, input logic r, input logic [4:0] d);
        return {w, r, 9'h0, d, 5'h0, pre, 2'h0};
    endfunction

    task automatic lat_of(input logic [4:0] n, output int lat);
        logic [5:0] prev;
        wr(`MCSS_ADDR_MSYNC, mk(4'h0, 1'b1, n));
        upd();
        wr(`MCSS_ADDR_STATUS, 32'h7);
        wr(`MCSS_ADDR_MASK, 32'h1);
        run <= 1'b1;
        for (int i = 0; i < 200 && sin_p !== 1'b1; i++) @(negedge clock_i);
        prev = state;
        // sync status marks the load even when the preset equals the next count
        for (lat = 1; lat < 60; lat++)
        begin
            @(negedge clock_i);
            if (irq === 1'b1)
                break;
            prev = state;
        end
        check("preset", prev, pre);
        check("resume", state, 6'(pre + 6'h01));
        rd(`MCSS_ADDR_STATE, {26'h0, 6'(pre + 6'h02)}, 32'h3f);
        run <= 1'b0;
        wr(`MCSS_ADDR_MASK, 32'h0);
        repeat (90) @(posedge clock_i);
    endtask

    initial
    begin
        #400000;
        errors++;
        give_verdict();
    end

    initial
    begin
        void'($urandom(32'hd27df54c));
        pre = 6'($urandom);
        n2 = 5'd1 + 5'($urandom % 8);
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd(`MCSS_ADDR_CTRL2, 32'h0, '1);
        rd(`MCSS_ADDR_MSYNC, 32'h0, '1);
        rd(`MCSS_ADDR_ACTIVE_MSYNC, 32'h0, '1);
        rd(`MCSS_ADDR_STATUS, 32'h0, '1);
        wr(5'h1f, 32'hffff_ffff);
        rd(5'h1f, 32'h0, '1);
        // buffered until the transfer strobe
        wr(`MCSS_ADDR_MSYNC, mk(4'h9, 1'b0, 5'h3));
        rd(`MCSS_ADDR_MSYNC, mk(4'h9, 1'b0, 5'h3), FMSK);
        rd(`MCSS_ADDR_ACTIVE_MSYNC, 32'h0, '1);
        upd();
        rd(`MCSS_ADDR_ACTIVE_MSYNC, mk(4'h9, 1'b0, 5'h3), FMSK);
        rd(`MCSS_ADDR_STATUS, 32'h4, 32'h4);
        // receiver off: no sync event, yet the counter keeps stepping
        wr(`MCSS_ADDR_STATUS, 32'h7);
        @(posedge clock_i);
        run <= 1'b1;
        @(negedge clock_i);
        s0 = state;
        repeat (120) @(negedge clock_i);
        check("free_run", state, 6'(s0 + 6'd56));
        @(posedge clock_i);
        run <= 1'b0;
        rd(`MCSS_ADDR_STATUS, 32'h0, 32'h3);
        lat_of(5'h0, l1);
        lat_of(n2, l2);
        check("in_delay", 32'(l2 - l1), 32'(n2));
        rd(`MCSS_ADDR_STATUS, 32'h1, 32'h1);
        // interrupt: masked, unmasked, cleared
        @(negedge clock_i);
        check("irq_masked", irq, 1'b0);
        wr(`MCSS_ADDR_MASK, 32'h7);
        repeat (3) @(negedge clock_i);
        check("irq_set", irq, 1'b1);
        wr(`MCSS_ADDR_STATUS, 32'h7);
        repeat (3) @(negedge clock_i);
        check("irq_clear", irq, 1'b0);
        // validation window of 4 against fast and slow input
        wr(`MCSS_ADDR_MSYNC, mk(4'h4, 1'b1, 5'h0));
        upd();
        half <= 6'd2;
        run <= 1'b1;
        repeat (40) @(negedge clock_i);
        check("err_fast", err, 1'b1);
        rd(`MCSS_ADDR_STATUS, 32'h2, 32'h2);
        @(posedge clock_i);
        half <= 6'd20;
        repeat (80) @(negedge clock_i);
        check("err_slow", err, 1'b0);
        wr(`MCSS_ADDR_CTRL2, 32'h20);
        upd();
        half <= 6'd2;
        repeat (40) @(negedge clock_i);
        check("err_dis", err, 1'b0);
        run <= 1'b0;
        check("gen_off", sout_p, 1'b0);
        // generator on, random launch polarity
        wr(`MCSS_ADDR_CTRL2, {30'h0, 1'($urandom), 1'b1});
        upd();
        for (int i = 0; i < 80 && sout_p !== 1'b1; i++) @(negedge clock_i);
        for (hi = 0; hi < 40 && sout_p === 1'b1; hi++) @(negedge clock_i);
        for (lo = 0; lo < 40 && sout_p === 1'b0; lo++) @(negedge clock_i);
        check("gen_high", 32'(hi), 32'd8);
        check("gen_low", 32'(lo), 32'd8);
        rd(`MCSS_ADDR_STATE, 32'h0, 32'hffff_ffc0);
        repeat (4) @(posedge clock_i);
        give_verdict();
    end
endmodule // tb_mcss_top

bind mcss_top mcss_top_properties #(.STATE_W(STATE_W)) i_mcss_top_properties (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .sync_input_pair_p_i(sync_input_pair_p_i),
    .sync_input_pair_n_i(sync_input_pair_n_i), .sync_output_pair_p_o(sync_output_pair_p_o),
    .sync_output_pair_n_o(sync_output_pair_n_o), .sync_sample_error_o(sync_sample_error_o),
    .clock_state_o(clock_state_o));
